// [rtl/boot_cfg_pkg.sv]
package boot_cfg_pkg;
  // ****************************************************************
  // widths and field layout
  // ****************************************************************
  localparam int ADDR_W = 32;
  localparam int WORD_ALIGN_BITS = 2;
  localparam int VEC_ALIGN_BITS = 7;
  localparam int CFG_W = 8;
  localparam int SEC_W = 3;
  localparam int MAX_REGIONS = 64;
  localparam int MAX_ATTR = 16;
  localparam int TRIG_MAX = 4;

  // ****************************************************************
  // reset values
  // ****************************************************************
  localparam logic [ADDR_W-1:0] PC_RESET = 32'h0000_0000;
  localparam logic [CFG_W-1:0] CFG_RESET = 8'h00;
  localparam logic [SEC_W-1:0] SEC_RESET = 3'h0;

  // ****************************************************************
  // configuration choices
  // ****************************************************************
  typedef enum logic {BASE_FULL, BASE_EMBEDDED} base_isa_t;
  typedef enum logic [1:0] {BIT_NONE, BIT_ABS, BIT_ABCS} bit_ext_t;
  typedef enum logic [1:0] {MUL_NONE, MUL_ONLY, MUL_DIV} mul_ext_t;

  // static address inputs travelling together
  typedef struct packed {
    logic [ADDR_W-1:0] boot;
    logic [ADDR_W-1:0] trap_vec;
    logic [ADDR_W-1:0] dbg_entry;
    logic [ADDR_W-1:0] dbg_fault;
  } boot_addrs_t;

  // one attribute region record
  typedef struct packed {
    logic [ADDR_W-1:0] base;
    logic [ADDR_W-1:0] limit;
    logic main_mem;
    logic bufferable;
    logic cacheable;
  } attr_cfg_t;

  // exposed state of the core front end
  typedef struct packed {
    logic [ADDR_W-1:0] pc;
    logic [ADDR_W-1:0] trap_base;
    logic fetching;
    logic in_debug;
  } core_state_t;
endpackage

// [rtl/gate_cell.sv]
`timescale 1ns/100ps
`default_nettype none
// latch-based gate model: enable passed while clock is low, forced by scan
module gate_cell #(
  parameter int cell_library_select = 0
) (
  // clock in and out
  input wire logic clk_in,
  output logic clk_out,
  // enables
  input wire logic func_enable,
  input wire logic scan_gate_override
);
  logic en_latched;

  // hold enable stable while clock is high
  always_latch begin
    if (!clk_in) begin
      en_latched <= func_enable | scan_gate_override;
    end
  end

  assign clk_out = clk_in & en_latched;
endmodule
`default_nettype wire

// [rtl/core_boot_config.sv]
`timescale 1ns/100ps
`default_nettype none
module core_boot_config
  import boot_cfg_pkg::*;
#(
  parameter int cell_library_select = 0,
  parameter boot_cfg_pkg::base_isa_t base_isa_select = BASE_FULL,
  parameter boot_cfg_pkg::bit_ext_t bit_ext_select = BIT_NONE,
  parameter boot_cfg_pkg::mul_ext_t mul_ext_select = MUL_DIV,
  parameter bit compressed_ext_enable = 1'b0,
  parameter int debug_trigger_count = 1,
  parameter int attr_region_count = 1,
  parameter boot_cfg_pkg::attr_cfg_t attr_cfg [attr_region_count] =
    '{default: '0},
  parameter int protect_grain = 0,
  parameter int protect_region_count = 1,
  parameter logic [boot_cfg_pkg::CFG_W-1:0]
    protect_cfg_reset_values [protect_region_count] = '{default: '0},
  parameter logic [boot_cfg_pkg::ADDR_W-1:0]
    protect_addr_reset_values [protect_region_count] = '{default: '0},
  parameter logic [boot_cfg_pkg::SEC_W-1:0] security_cfg_reset_value =
    3'h0,
  parameter bit irq_ctrl_enable = 1'b0,
  parameter int irq_ident_width = 5
) (
  // clock and reset
  input wire logic mclk,
  input wire logic resetn,
  input wire logic scan_gate_override,
  // static configuration
  input wire boot_cfg_pkg::boot_addrs_t addrs,
  input wire logic fetch_enable,
  // core events
  input wire logic debug_enter,
  input wire logic debug_fault,
  input wire logic pc_advance,
  input wire logic sleep_req,
  input wire logic [irq_ident_width-1:0] irq_ident_in,
  // front end state
  output boot_cfg_pkg::core_state_t state,
  output logic fetch_req,
  output logic [irq_ident_width-1:0] irq_ident_out,
  output logic gated_clk,
  // configuration readback
  output logic [boot_cfg_pkg::CFG_W-1:0]
    protect_cfg_out [protect_region_count],
  output logic [boot_cfg_pkg::ADDR_W-1:0]
    protect_addr_out [protect_region_count],
  output logic [boot_cfg_pkg::SEC_W-1:0] security_cfg_out,
  output logic [boot_cfg_pkg::ADDR_W-1:0] grain_mask_out,
  output logic [3:0] feature_flags_out
);
  import boot_cfg_pkg::*;

  // ****************************************************************
  // values derived from parameters
  // ****************************************************************
  localparam int GRAIN_SH = (protect_grain > 29) ? 29 : protect_grain;
  localparam logic [ADDR_W-1:0] GRAIN_MASK =
    ADDR_W'(~((64'h0000_0000_0000_0004 << GRAIN_SH) - 64'h1));
  localparam bit HAS_BITM = (bit_ext_select != BIT_NONE);
  localparam bit HAS_CLMUL = (bit_ext_select == BIT_ABCS);
  localparam bit HAS_DIV = (mul_ext_select == MUL_DIV);
  localparam bit HAS_MUL = (mul_ext_select != MUL_NONE);
  localparam int REG_COUNT = (base_isa_select == BASE_FULL) ? 32 : 16;

  // ****************************************************************
  // reset release
  // ****************************************************************
  logic rst_meta_reg;
  logic rst_sync_reg;

  // asynchronous assert, synchronous release
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      rst_meta_reg <= 1'b0;
      rst_sync_reg <= 1'b0;
    end else begin
      rst_meta_reg <= 1'b1;
      rst_sync_reg <= rst_meta_reg;
    end
  end

  wire rst_n = rst_sync_reg;

  // ****************************************************************
  // input synchronisers
  // ****************************************************************
  logic fe_meta_reg;
  logic fe_sync_reg;
  logic [irq_ident_width-1:0] id_meta_reg;
  logic [irq_ident_width-1:0] id_sync_reg;

  // pin inputs pass two flops
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      fe_meta_reg <= 1'b0;
      fe_sync_reg <= 1'b0;
      id_meta_reg <= '0;
      id_sync_reg <= '0;
    end else begin
      fe_meta_reg <= fetch_enable;
      fe_sync_reg <= fe_meta_reg;
      id_meta_reg <= irq_ident_in;
      id_sync_reg <= id_meta_reg;
    end
  end

  // ****************************************************************
  // fetch control
  // ****************************************************************
  typedef enum logic [1:0] {WAIT_ENABLE, RUN, DEBUG} fetch_state_t;
  fetch_state_t fsm_reg;
  fetch_state_t fsm_next;
  logic [ADDR_W-1:0] pc_reg;
  logic [ADDR_W-1:0] pc_next;
  logic [ADDR_W-1:0] trap_reg;
  logic first_reg;
  logic debug_reg;

  // next state; fetch enable looked at only while waiting
  always_comb begin
    fsm_next = fsm_reg;
    case (fsm_reg)
      WAIT_ENABLE: begin
        if (fe_sync_reg) begin
          fsm_next = RUN;
        end
      end
      RUN: begin
        if (debug_enter) begin
          fsm_next = DEBUG;
        end
      end
      DEBUG: begin
        fsm_next = DEBUG;
      end
      default: begin
        fsm_next = WAIT_ENABLE;
      end
    endcase
  end

  wire in_run = (fsm_reg != WAIT_ENABLE);
  wire [ADDR_W-1:0] step = ADDR_W'(compressed_ext_enable ? 2 : 4);

  // pc selection: debug fault, debug entry, sequential step
  assign pc_next =
    (in_run && fsm_reg == DEBUG && debug_fault) ? addrs.dbg_fault :
    (in_run && fsm_reg == RUN && debug_enter) ? addrs.dbg_entry :
    (in_run && pc_advance && !first_reg) ? pc_reg + step :
    pc_reg;

  // first pc comes straight from boot address at start
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      fsm_reg <= WAIT_ENABLE;
      pc_reg <= PC_RESET;
      first_reg <= 1'b1;
    end else begin
      fsm_reg <= fsm_next;
      if (fsm_reg == WAIT_ENABLE) begin
        pc_reg <= addrs.boot;
      end else begin
        pc_reg <= pc_next;
        first_reg <= first_reg & ~pc_advance;
      end
    end
  end

  // trap base loaded every cycle while waiting for fetch enable when controller absent
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      trap_reg <= PC_RESET;
    end else if (fsm_reg == WAIT_ENABLE && !irq_ctrl_enable) begin
      trap_reg <= {addrs.trap_vec[ADDR_W-1:VEC_ALIGN_BITS],
                   VEC_ALIGN_BITS'(0)};
    end
  end

  // outputs from flops
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      fetch_req <= 1'b0;
      irq_ident_out <= '0;
      debug_reg <= 1'b0;
    end else begin
      fetch_req <= (fsm_next != WAIT_ENABLE);
      debug_reg <= (fsm_next == DEBUG);
      irq_ident_out <= irq_ctrl_enable ? id_sync_reg : '0;
    end
  end

  assign state.pc = pc_reg;
  assign state.trap_base = trap_reg;
  assign state.fetching = fetch_req;
  assign state.in_debug = debug_reg;

  // ****************************************************************
  // protection registers
  // ****************************************************************
  logic [CFG_W-1:0] pcfg_reg [protect_region_count];
  logic [ADDR_W-1:0] paddr_reg [protect_region_count];
  logic [SEC_W-1:0] sec_reg;

  // each region loads its reset values from the parameter arrays
  genvar gi;
  generate
    for (gi = 0; gi < protect_region_count; gi++) begin : g_reg
      always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
          pcfg_reg[gi] <= protect_cfg_reset_values[gi];
          paddr_reg[gi] <= protect_addr_reset_values[gi];
        end
      end
      assign protect_cfg_out[gi] = pcfg_reg[gi];
      assign protect_addr_out[gi] = paddr_reg[gi] & GRAIN_MASK;
    end
  endgenerate

  // security configuration reset value
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      sec_reg <= security_cfg_reset_value;
    end
  end

  assign security_cfg_out = sec_reg;

  // ****************************************************************
  // feature flags and attribute region summary
  // ****************************************************************
  logic [3:0] flags_reg;
  logic [ADDR_W-1:0] mask_reg;

  wire attr_main0 = attr_cfg[0].main_mem;
  wire has_trig = (debug_trigger_count > 0);

  // registered summary of elaborated options
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      flags_reg <= 4'h0;
      mask_reg <= 32'h0000_0000;
    end else begin
      flags_reg <= {HAS_BITM | HAS_CLMUL, HAS_MUL | HAS_DIV,
                    has_trig & (REG_COUNT > 0), attr_main0};
      mask_reg <= GRAIN_MASK;
    end
  end

  assign feature_flags_out = flags_reg;
  assign grain_mask_out = mask_reg;

  // ****************************************************************
  // sleep clock gate
  // ****************************************************************
  gate_cell #(
    .cell_library_select(cell_library_select)
  ) u_gate (
    .clk_in(mclk),
    .clk_out(gated_clk),
    .func_enable(~sleep_req),
    .scan_gate_override(scan_gate_override)
  );

  // ****************************************************************
  // checks
  // ****************************************************************
  first_pc_a: assert property (@(posedge mclk) disable iff (!rst_n)
    (rst_n && fsm_reg == WAIT_ENABLE) |=> (pc_reg == $past(addrs.boot)))
    else $error("pc not loaded from boot address");
  no_early_fetch_a: assert property (@(posedge mclk) disable iff (!rst_n)
    (!fe_sync_reg && fsm_reg == WAIT_ENABLE) |=> !fetch_req)
    else $error("fetch before enable");
  fetch_sticks_a: assert property (@(posedge mclk) disable iff (!rst_n)
    fetch_req |=> fetch_req)
    else $error("fetch dropped after start");
  debug_entry_a: assert property (@(posedge mclk) disable iff (!rst_n)
    (fsm_reg == RUN && debug_enter) |=> (pc_reg == $past(addrs.dbg_entry)))
    else $error("debug entry target missed");
  debug_fault_a: assert property (@(posedge mclk) disable iff (!rst_n)
    (fsm_reg == DEBUG && debug_fault) |=>
      (pc_reg == $past(addrs.dbg_fault)))
    else $error("debug fault target missed");
  trap_base_a: assert property (@(posedge mclk) disable iff (!rst_n)
    $rose(fetch_req) && !irq_ctrl_enable |->
      (trap_reg[VEC_ALIGN_BITS-1:0] == '0))
    else $error("trap base low bits set");
  sec_hold_a: assert property (@(posedge mclk) disable iff (!rst_n)
    sec_reg == security_cfg_reset_value)
    else $error("security cfg lost reset value");
  cfg_hold_a: assert property (@(posedge mclk) disable iff (!rst_n)
    pcfg_reg[0] == protect_cfg_reset_values[0])
    else $error("region cfg lost reset value");
  addr_hold_a: assert property (@(posedge mclk) disable iff (!rst_n)
    paddr_reg[0] == protect_addr_reset_values[0])
    else $error("region addr lost reset value");
  reset_rel_a: assert property (@(posedge mclk)
    !resetn |=> !rst_sync_reg)
    else $error("reset released too early");
  scan_gate_a: assert property (@(posedge mclk)
    scan_gate_override |-> ##1 u_gate.en_latched)
    else $error("scan override did not open gate");
  pc_step_a: assert property (@(posedge mclk) disable iff (!rst_n)
    (fsm_reg == RUN && pc_advance && !first_reg && !debug_enter) |=>
      (pc_reg == $past(pc_reg) + ADDR_W'(compressed_ext_enable ? 2 : 4)))
    else $error("pc step size wrong");
  first_hold_a: assert property (@(posedge mclk) disable iff (!rst_n)
    (fsm_reg == RUN && first_reg && !debug_enter) |=> $stable(pc_reg))
    else $error("boot pc moved on first advance");
  trap_load_a: assert property (@(posedge mclk) disable iff (!rst_n)
    (rst_n && fsm_reg == WAIT_ENABLE && !irq_ctrl_enable) |=>
      (trap_reg[ADDR_W-1:VEC_ALIGN_BITS] ==
       $past(addrs.trap_vec[ADDR_W-1:VEC_ALIGN_BITS])))
    else $error("trap base not loaded from vector input");
  debug_stay_a: assert property (@(posedge mclk) disable iff (!rst_n)
    (fsm_reg == DEBUG) |=> (fsm_reg == DEBUG))
    else $error("left debug before reset");
  debug_flag_a: assert property (@(posedge mclk) disable iff (!rst_n)
    debug_reg == (fsm_reg == DEBUG))
    else $error("debug flag out of step");
endmodule
`default_nettype wire

// [bench/sys_cfg_model.sv]
`timescale 1ns/100ps
`default_nettype none
// system side: aligned static addresses and a short fetch enable pulse
module sys_cfg_model (
  // clock
  input wire logic mclk,
  // bench control
  input wire logic start,
  input wire logic scan_test,
  input wire boot_cfg_pkg::boot_addrs_t raw,
  // towards the core
  output boot_cfg_pkg::boot_addrs_t addrs,
  output logic fetch_enable,
  output logic scan_gate_override
);
  import boot_cfg_pkg::*;

  boot_addrs_t addrs_reg = '0;
  logic start_reg = 1'b0;
  logic [2:0] hold_reg = 3'h0;

  // addresses follow raw only until the core is enabled
  always_ff @(posedge mclk) begin
    start_reg <= start;
    if (!start) begin
      addrs_reg.boot <= raw.boot & ~32'h0000_0003;
      addrs_reg.trap_vec <= raw.trap_vec & ~32'h0000_007f;
      addrs_reg.dbg_entry <= raw.dbg_entry & ~32'h0000_0003;
      addrs_reg.dbg_fault <= raw.dbg_fault & ~32'h0000_0003;
    end
    if (start && !start_reg) begin
      hold_reg <= 3'h4;
    end else if (hold_reg != 3'h0) begin
      hold_reg <= hold_reg - 3'h1;
    end
  end

  // outputs
  assign addrs = addrs_reg;
  assign fetch_enable = (hold_reg != 3'h0);
  assign scan_gate_override = scan_test;
endmodule
`default_nettype wire

// [bench/tb_top.sv]
`timescale 1ns/100ps
`default_nettype none
module tb_top;
  import boot_cfg_pkg::*;
  localparam int NREG = 2;
  localparam logic [CFG_W-1:0] CFG_RV [NREG] = '{8'h1f, 8'h88};
  localparam logic [ADDR_W-1:0] ADDR_RV [NREG] =
    '{32'h0000_1000, 32'h8000_0004};
  localparam logic [SEC_W-1:0] SEC_RV = 3'h5;

  logic mclk = 1'b0;
  logic resetn = 1'b0;
  logic start = 1'b0;
  logic scan_test = 1'b0;
  logic debug_enter = 1'b0;
  logic debug_fault = 1'b0;
  logic pc_advance = 1'b0;
  logic sleep_req = 1'b0;
  logic [4:0] irq_in = 5'h00;
  boot_addrs_t raw = '0;
  boot_addrs_t addrs;
  core_state_t state;
  logic fetch_enable, scan_gate_override, fetch_req, gated_clk;
  logic [4:0] irq_out;
  logic [CFG_W-1:0] pcfg [NREG];
  logic [ADDR_W-1:0] paddr [NREG];
  logic [SEC_W-1:0] sec;
  logic [ADDR_W-1:0] gmask;
  logic [3:0] flags;
  int err_total = 0;
  int compares = 0;

  // clock, 4 ns period
  always #2 mclk = ~mclk;

  sys_cfg_model sys_u (.mclk(mclk), .start(start), .scan_test(scan_test),
    .raw(raw), .addrs(addrs), .fetch_enable(fetch_enable),
    .scan_gate_override(scan_gate_override));

  core_boot_config #(.protect_region_count(NREG),
    .protect_cfg_reset_values(CFG_RV), .protect_addr_reset_values(ADDR_RV),
    .security_cfg_reset_value(SEC_RV)) dut_u (
    .mclk(mclk), .resetn(resetn), .scan_gate_override(scan_gate_override),
    .addrs(addrs), .fetch_enable(fetch_enable), .debug_enter(debug_enter),
    .debug_fault(debug_fault), .pc_advance(pc_advance),
    .sleep_req(sleep_req), .irq_ident_in(irq_in), .state(state),
    .fetch_req(fetch_req), .irq_ident_out(irq_out), .gated_clk(gated_clk),
    .protect_cfg_out(pcfg), .protect_addr_out(paddr),
    .security_cfg_out(sec), .grain_mask_out(gmask),
    .feature_flags_out(flags));

  // ****************************************************************
  // helpers
  // ****************************************************************
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
      err_total++;
    end
  endtask

  task automatic tally_and_finish();
    $display("checks=%0d mismatches=%0d", compares, err_total);
    if (err_total == 0 && compares > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  // expected word aligned address
  function automatic logic [31:0] word_al(input logic [31:0] a);
    return a & ~32'h0000_0003;
  endfunction

  // one cycle event pulse, ends one edge after the event is taken
  task automatic pulse(input int which);
    @(posedge mclk);
    case (which)
      0: pc_advance <= 1'b1;
      1: debug_enter <= 1'b1;
      default: debug_fault <= 1'b1;
    endcase
    @(posedge mclk);
    pc_advance <= 1'b0;
    debug_enter <= 1'b0;
    debug_fault <= 1'b0;
    @(posedge mclk);
    #1;
  endtask

  task automatic do_reset();
    @(posedge mclk);
    start <= 1'b0;
    resetn <= 1'b0;
    #1;
    check(fetch_req, 0);
    repeat (3) @(posedge mclk);
    resetn <= 1'b1;
    repeat (6) @(posedge mclk);
    #1;
  endtask

  // ****************************************************************
  // main sequence
  // ****************************************************************
  initial begin
    int n;
    void'($urandom(48));
    for (int it = 0; it < 4; it++) begin
      @(posedge mclk);
      if (it == 0) begin
        raw <= '1;
      end else begin
        raw <= '{$urandom, $urandom, $urandom, $urandom};
      end
      irq_in <= 5'($urandom);
      do_reset();
      for (int i = 0; i < NREG; i++) begin
        check(32'(pcfg[i]), 32'(CFG_RV[i]));
        check(paddr[i], word_al(ADDR_RV[i]));
      end
      check(32'(sec), 32'(SEC_RV));
      check(fetch_req, 0);
      @(posedge mclk);
      start <= 1'b1;
      n = 0;
      while (fetch_req !== 1'b1) begin
        @(posedge mclk);
        #1;
        n++;
        if (n > 20) begin
          err_total++;
          tally_and_finish();
        end
      end
      check(state.pc, word_al(raw.boot));
      check(state.trap_base, raw.trap_vec & ~32'h0000_007f);
      check(32'(irq_out), 0);
      check(gmask, 32'hffff_fffc);
      check(32'(flags), 32'h0000_0006);
      check(state.fetching, 1);
      repeat (8) @(posedge mclk);
      #1;
      check(fetch_req, 1);
      pulse(2);
      check(state.pc, word_al(raw.boot));
      check(state.in_debug, 0);
      pulse(0);
      pulse(0);
      check(state.pc, word_al(raw.boot) + 32'h0000_0004);
      pulse(1);
      check(state.pc, word_al(raw.dbg_entry));
      check(state.in_debug, 1);
      pulse(2);
      check(state.pc, word_al(raw.dbg_fault));
      @(posedge mclk);
      sleep_req <= 1'b1;
      repeat (3) @(posedge mclk);
      #1;
      check(gated_clk, 0);
      @(posedge mclk);
      scan_test <= 1'b1;
      repeat (3) @(posedge mclk);
      #1;
      check(gated_clk, 1);
      @(posedge mclk);
      scan_test <= 1'b0;
      sleep_req <= 1'b0;
      $display("test %0d done, mismatches so far %0d", it, err_total);
    end
    tally_and_finish();
  end
endmodule
`default_nettype wire
